// ==== hw/arsk_consts.vh ====
`ifndef ARSK_CONSTS_VH
`define ARSK_CONSTS_VH
// Operation select codes
`define ARSK_OP_W 4
`define ARSK_OP_NONE 4'h0
`define ARSK_OP_ROT_CARRY_ACC 4'h1
`define ARSK_OP_BORROW_ACC 4'h2
`define ARSK_OP_BORROW_MEM 4'h3
`define ARSK_OP_SUB_ACC 4'h4
`define ARSK_OP_SUB_MEM 4'h5
`define ARSK_OP_SUB_IMM 4'h6
`define ARSK_OP_DEC_MEM 4'h7
`define ARSK_OP_DEC_ACC 4'h8
`define ARSK_OP_INC_MEM 4'h9
`define ARSK_OP_INC_ACC 4'hA
`define ARSK_OP_SET_BYTE 4'hB
`define ARSK_OP_SET_BIT 4'hC
`define ARSK_OP_BIT_SKIP 4'hD
`define ARSK_OP_SWAP 4'hE
// Flag vector bit positions {ov,z,ac,c}
`define ARSK_FLAG_C 0
`define ARSK_FLAG_AC 1
`define ARSK_FLAG_Z 2
`define ARSK_FLAG_OV 3
// Reset values and datapath constants
`define ARSK_ACC_RST 8'h00
`define ARSK_FLAGS_RST 4'h0
`define ARSK_ALL_ONES 8'hFF
`define ARSK_ONE 8'h01
// Cycles taken by a skipping instruction
`define ARSK_SKIP_CYCLES 2
`endif

// ==== hw/arsk_alu.v ====
// What this block does
// - Rotate-right-through-carry puts old carry in acc bit 7, operand bit 0 in carry, memory kept.
// - Subtract-with-borrow gives acc + ~m + c to acc or memory, updating ov, z, ac and c.
// - Subtract-memory gives acc + ~m + 1 to acc or memory, updating ov, z, ac and c.
// - Subtract-immediate gives acc + ~imm + 1 to acc, updating ov, z, ac and c.
// - Decrement-skip writes m - 1 back and skips on zero, flags untouched.
// - Decrement-to-acc puts m - 1 in acc, memory kept, skips on zero, flags untouched.
// - Increment-skip writes m + 1 back and skips on zero, flags untouched.
// - Increment-to-acc puts m + 1 in acc, memory kept, skips on zero, flags untouched.
// - A taken skip discards the prefetched instruction with one dummy cycle, else one cycle.
// - Whole-byte set writes all ones to memory, flags untouched.
// - Bit set forces the selected bit to one, others kept, flags untouched.
// - Bit-test skip skips when the selected bit is one, nothing modified.
// - Nibble swap exchanges the two halves of the operand in place, flags untouched.
`timescale 1ns/100ps
`include "arsk_consts.vh"

module arsk_alu #(
	parameter DW = 8
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_nrst,
	// Instruction issue
	input wire i_valid,
	input wire [3:0] i_op,
	input wire [DW-1:0] i_mem,
	input wire [DW-1:0] i_imm,
	input wire [2:0] i_bit_sel,
	// Results
	output reg [DW-1:0] o_acc,
	output reg [3:0] o_flags,
	output reg [DW-1:0] o_mem_wdata,
	output reg o_mem_we,
	output reg o_skip,
	output reg o_busy,
	output reg o_done
);

	localparam ST_RUN = 1'b0;
	localparam ST_DUMMY = 1'b1;

	reg state_r;
	reg [DW-1:0] res;
	reg to_acc;
	reg to_mem;
	reg skip;
	reg [3:0] fl;
	reg [DW:0] sum;
	reg [DW-1:0] opb;
	reg cin;
	reg arith;
	wire [DW-1:0] bit_mask;

	// Next values of the retiring registers, captured by the flops at the bottom
	reg state_nxt;
	reg [DW-1:0] acc_nxt;
	reg [3:0] flags_nxt;
	reg [DW-1:0] wdata_nxt;
	reg we_nxt;
	reg skip_nxt;
	reg busy_nxt;
	reg done_nxt;

	// Zero test shared by the decrement and increment skip decisions and the zero flag
	function is_zero;
		input [DW-1:0] val;
		begin
			is_zero = (val == {DW{1'b0}});
		end
	endfunction

	// Flags of a subtract done as a + b + cin, with b already inverted
	function [3:0] sub_flags;
		input [DW-1:0] a;
		input [DW-1:0] b;
		input c_in;
		reg [DW:0] full;
		reg [4:0] low;
		begin
			full = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, c_in};
			low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c_in};
			// Carry set means no borrow was needed
			sub_flags[`ARSK_FLAG_C] = full[DW];
			sub_flags[`ARSK_FLAG_AC] = low[4];
			sub_flags[`ARSK_FLAG_Z] = is_zero(full[DW-1:0]);
			// Overflow when both inputs share a sign the result lacks
			sub_flags[`ARSK_FLAG_OV] = (a[DW-1] == b[DW-1]) && (full[DW-1] != a[DW-1]);
		end
	endfunction

	// One-hot mask for the selected bit, one comparator per position
	genvar gi;
	generate
		for (gi = 0; gi < DW; gi = gi + 1) begin : g_mask
			assign bit_mask[gi] = (i_bit_sel == gi);
		end
	endgenerate

	// Datapath overview:
	// Every operation but subtract-immediate and whole-byte set reads the memory operand as it stands on i_mem in the
	// issue cycle and produces one result byte in res.
	// The result is steered to the accumulator, to the memory write port,
	// or to both sides of nothing (bit test), by to_acc and to_mem.
	// All subtract forms share one adder: acc + ~operand + carry-in, where
	// the carry-in is the stored carry for the borrow forms and one otherwise.
	// Keeping a single adder trades a little decode logic for area.
	// Skip decisions come straight from the result or the tested bit, so the
	// sequencer below never has to look at the operand itself.
	// Flags default to their stored value, so any op that does not touch
	// them writes the same bits back and leaves them as they were.
	// Limitation: the nibble swap is wired for an 8-bit operand only.

	// Decode and compute one instruction
	always @* begin
		res = i_mem;
		to_acc = 1'b0;
		to_mem = 1'b0;
		skip = 1'b0;
		fl = o_flags;
		opb = ~i_mem;
		cin = 1'b1;
		arith = 1'b0;
		case (i_op)
			`ARSK_OP_ROT_CARRY_ACC: begin
				res = {o_flags[`ARSK_FLAG_C], i_mem[DW-1:1]};
				fl[`ARSK_FLAG_C] = i_mem[0];
				to_acc = 1'b1;
			end
			`ARSK_OP_BORROW_ACC, `ARSK_OP_BORROW_MEM: begin
				cin = o_flags[`ARSK_FLAG_C];
				arith = 1'b1;
				to_acc = (i_op == `ARSK_OP_BORROW_ACC);
				to_mem = (i_op == `ARSK_OP_BORROW_MEM);
			end
			`ARSK_OP_SUB_ACC, `ARSK_OP_SUB_MEM: begin
				arith = 1'b1;
				to_acc = (i_op == `ARSK_OP_SUB_ACC);
				to_mem = (i_op == `ARSK_OP_SUB_MEM);
			end
			`ARSK_OP_SUB_IMM: begin
				opb = ~i_imm;
				arith = 1'b1;
				to_acc = 1'b1;
			end
			`ARSK_OP_DEC_MEM, `ARSK_OP_DEC_ACC: begin
				res = i_mem - `ARSK_ONE;
				skip = is_zero(res);
				to_mem = (i_op == `ARSK_OP_DEC_MEM);
				to_acc = (i_op == `ARSK_OP_DEC_ACC);
			end
			`ARSK_OP_INC_MEM, `ARSK_OP_INC_ACC: begin
				res = i_mem + `ARSK_ONE;
				skip = is_zero(res);
				to_mem = (i_op == `ARSK_OP_INC_MEM);
				to_acc = (i_op == `ARSK_OP_INC_ACC);
			end
			`ARSK_OP_SET_BYTE: begin
				res = `ARSK_ALL_ONES;
				to_mem = 1'b1;
			end
			`ARSK_OP_SET_BIT: begin
				res = i_mem | bit_mask;
				to_mem = 1'b1;
			end
			`ARSK_OP_BIT_SKIP: begin
				skip = |(i_mem & bit_mask);
			end
			`ARSK_OP_SWAP: begin
				res = {i_mem[3:0], i_mem[7:4]};
				to_mem = 1'b1;
			end
			default: begin
				res = i_mem;
			end
		endcase
		// Shared adder for every subtract form
		sum = {1'b0, o_acc} + {1'b0, opb} + {{DW{1'b0}}, cin};
		if (arith) begin
			res = sum[DW-1:0];
			// All four arithmetic flags are replaced together
			fl = sub_flags(o_acc, opb, cin);
		end
	end

	// Sequencing overview:
	// An instruction is taken on the edge where i_valid is high in ST_RUN.
	// Its results, the write strobe and the skip pulse all appear one cycle
	// later, straight from flops, so the core sees settled values.
	// A taken skip parks the sequencer in ST_DUMMY for one cycle, which
	// stands in for the prefetched instruction that has to be thrown away.
	// Anything offered on i_valid during that cycle is dropped on purpose:
	// the core must not issue there, and nothing reports the drop.
	// Splitting next-value logic from the flops keeps every output a bare
	// register while the decisions stay readable in one place.

	// Next values; write strobe, skip and done fall back to zero unless set this cycle, busy holds until cleared
	always @* begin
		state_nxt = state_r;
		acc_nxt = o_acc;
		flags_nxt = o_flags;
		wdata_nxt = o_mem_wdata;
		we_nxt = 1'b0;
		skip_nxt = 1'b0;
		busy_nxt = o_busy;
		done_nxt = 1'b0;
		case (state_r)
			ST_RUN: begin
				if (i_valid) begin
					if (to_acc) begin
						acc_nxt = res;
					end
					flags_nxt = fl;
					we_nxt = to_mem;
					wdata_nxt = res;
					if (skip) begin
						skip_nxt = 1'b1;
						busy_nxt = 1'b1;
						state_nxt = ST_DUMMY;
					end else begin
						done_nxt = 1'b1;
					end
				end
			end
			default: begin
				// Dummy cycle replaces the discarded prefetch
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				state_nxt = ST_RUN;
			end
		endcase
	end

	// Sequencer state
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Accumulator and status flags
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_acc <= `ARSK_ACC_RST;
			o_flags <= `ARSK_FLAGS_RST;
		end else begin
			o_acc <= acc_nxt;
			o_flags <= flags_nxt;
		end
	end

	// Memory write port; data takes the result of every issued op, strobed or not
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_mem_wdata <= {DW{1'b0}};
			o_mem_we <= 1'b0;
		end else begin
			o_mem_wdata <= wdata_nxt;
			o_mem_we <= we_nxt;
		end
	end

	// Handshake pulses towards the core
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_skip <= 1'b0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_skip <= skip_nxt;
			o_busy <= busy_nxt;
			o_done <= done_nxt;
		end
	end

endmodule // arsk_alu

// ==== test/arsk_alu_checker.sv ====
`timescale 1ns/100ps
`include "arsk_consts.vh"
module arsk_alu_checker #(parameter DW = 8) (
	input wire i_sys_clk,
	input wire i_nrst,
	input wire i_valid,
	input wire [3:0] i_op,
	input wire [DW-1:0] i_mem,
	input wire [DW-1:0] i_imm,
	input wire [2:0] i_bit_sel,
	input wire [DW-1:0] o_acc,
	input wire [3:0] o_flags,
	input wire [DW-1:0] o_mem_wdata,
	input wire o_mem_we,
	input wire o_skip,
	input wire o_busy,
	input wire o_done
);
	// Single domain, so clock and reset are given once
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	// Taken only outside the dummy cycle
	wire ac = i_valid & ~o_busy;
	a_skip_done: assert property (o_skip |=> o_done&&!o_busy) else $error("dummy");
	a_skip_busy: assert property (o_skip |-> o_busy) else $error("busy");
	a_rot_carry: assert property (ac&&i_op==`ARSK_OP_ROT_CARRY_ACC |=>
		o_acc=={$past(o_flags[0]),$past(i_mem[7:1])}&&o_flags[0]==$past(i_mem[0])) else $error("rot");
	a_sub_imm: assert property (ac&&i_op==`ARSK_OP_SUB_IMM |=>
		o_acc==$past(o_acc)-$past(i_imm)&&o_flags[0]==($past(o_acc)>=$past(i_imm))) else $error("sub");
	a_inc_wrap: assert property (ac&&i_op==`ARSK_OP_INC_MEM&&i_mem==8'hFF |=>
		o_skip&&o_mem_we&&o_mem_wdata==8'h00) else $error("wrap");
	a_dec_acc: assert property (ac&&i_op==`ARSK_OP_DEC_ACC |=>
		o_acc==$past(i_mem)-8'h01&&!o_mem_we) else $error("dec");
	a_flag_keep: assert property (ac&&i_op>=`ARSK_OP_DEC_MEM |=>
		$stable(o_flags)) else $error("flags");
	a_bit_skip: assert property (ac&&i_op==`ARSK_OP_BIT_SKIP |=>
		o_skip==$past(i_mem[i_bit_sel])) else $error("bit");
	c_skip: cover property (o_skip);
	c_write: cover property (o_mem_we);
	c_done: cover property (o_done);
endmodule // arsk_alu_checker
bind arsk_alu arsk_alu_checker #(.DW(DW)) u_chk (.*);

// ==== test/arsk_alu_tb.sv ====
`timescale 1ns/100ps
`include "arsk_consts.vh"
module arsk_alu_tb;
	reg c = 1'b0;
	reg nrst = 1'b0;
	reg v = 1'b0;
	reg [3:0] op = 4'h0;
	reg [7:0] m = 8'h00;
	reg [2:0] b = 3'h0;
	wire [7:0] a;
	wire [7:0] w;
	wire [3:0] f;
	wire we, sk, dn, bz;
	int fail_count = 0;
	int checked = 0;
	arsk_alu dut (.i_sys_clk(c), .i_nrst(nrst), .i_valid(v), .i_op(op), .i_mem(m), .i_imm(~m),
		.i_bit_sel(b), .o_acc(a), .o_flags(f), .o_mem_wdata(w), .o_mem_we(we), .o_skip(sk),
		.o_busy(bz), .o_done(dn));
	initial forever #10 c = ~c;
	task chk(input string s, input [7:0] e, g);
		checked++;
		if (e !== g) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// Issue one op; a skip needs an idle cycle for its dummy slot
	task r(input [3:0] o, input [7:0] mm, ea, input [3:0] ef, input ew, input [7:0] ed, input es);
		@(negedge c) {v, op, m} = {1'b1, o, mm};
		@(negedge c) v = 1'b0;
		chk("acc", ea, a);
		chk("flags", ef, f);
		chk("we", ew, we);
		if (ew) chk("wdata", ed, w);
		chk("skip", es, sk);
		chk("busy", es, bz);
		chk("done", !es, dn);
		if (es) begin
			@(negedge c);
			chk("dummy busy", 8'h00, bz);
			chk("dummy done", 8'h01, dn);
		end
	endtask
	// Immediate is the inverse of m, so a datapath reading m here would fail
	task t_arith;
		r(`ARSK_OP_SUB_IMM,8'hFF,8'h00,4'h7,0,8'h00,0);
		r(`ARSK_OP_BORROW_ACC,8'h01,8'hFF,4'h0,0,8'h00,0);
		r(`ARSK_OP_SUB_ACC,8'h80,8'h7F,4'h3,0,8'h00,0);
		r(`ARSK_OP_BORROW_MEM,8'h7F,8'h7F,4'h7,1,8'h00,0);
		r(`ARSK_OP_SUB_MEM,8'hFF,8'h7F,4'hA,1,8'h80,0);
		r(`ARSK_OP_ROT_CARRY_ACC,8'h03,8'h01,4'hB,0,8'h00,0);
		r(`ARSK_OP_ROT_CARRY_ACC,8'h02,8'h81,4'hA,0,8'h00,0);
	endtask
	task t_skip;
		r(`ARSK_OP_DEC_MEM,8'h01,8'h81,4'hA,1,8'h00,1);
		r(`ARSK_OP_DEC_MEM,8'h00,8'h81,4'hA,1,8'hFF,0);
		r(`ARSK_OP_DEC_ACC,8'h01,8'h00,4'hA,0,8'h00,1);
		r(`ARSK_OP_INC_ACC,8'hFF,8'h00,4'hA,0,8'h00,1);
		r(`ARSK_OP_INC_MEM,8'hFF,8'h00,4'hA,1,8'h00,1);
	endtask
	task t_bits;
		b = 3'h5;
		r(`ARSK_OP_SET_BYTE,8'h12,8'h00,4'hA,1,8'hFF,0);
		r(`ARSK_OP_SET_BIT,8'h00,8'h00,4'hA,1,8'h20,0);
		r(`ARSK_OP_BIT_SKIP,8'h20,8'h00,4'hA,0,8'h00,1);
		r(`ARSK_OP_BIT_SKIP,8'hDF,8'h00,4'hA,0,8'h00,0);
		r(`ARSK_OP_SWAP,8'h3C,8'h00,4'hA,1,8'hC3,0);
		r(`ARSK_OP_NONE,8'h55,8'h00,4'hA,0,8'h00,0);
	endtask
	task tally_and_finish;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge c);
		nrst = 1'b1;
		t_arith;
		t_skip;
		t_bits;
		tally_and_finish;
	end
	// Run needs about 43 cycles; allow plenty
	initial begin
		#5000;
		fail_count++;
		tally_and_finish;
	end
endmodule // arsk_alu_tb
